// ===== src/mac_transmit_control.sv
// transmit control: control register, transmit queue, checksum insertion,
// padding, fcs append and flow control toward the line
// assumes host port, queue writer and line side all run on clk_i
// How it works
// - icmp checksum inserted in unfragmented icmp frames
// - udp checksum inserted in unfragmented udp frames
// - tcp checksum inserted in unfragmented tcp frames
// - ip header checksum inserted in unfragmented frames
// - flush resets pointers and clears queue memory one word per cycle while the bit stays set
// - full duplex: pause frame at receive threshold
// - half duplex back-pressure; disabled means no control
// - pad short packets up to minimum length
// - fcs appended to every frame when enabled
// - transmit enable starts the running state
// - disable stops only after current frame ends
`timescale 1ns/10ps
module mac_transmit_control
  import mac_tx_pkg::*;
#(
  parameter int              AW           = 11,
  parameter int              LW           = 11,
  parameter logic [LW-1:0]   PAUSE_THRESH = LW'(1536),
  parameter logic [15:0]     PAUSE_QUANTA = 16'hFFFF
) (
  // clock and reset
  input  logic        clk_i,
  input  logic        rst_i,
  // host register port
  input  logic [11:0] reg_addr_i,
  input  logic        reg_wr_i,
  input  logic        reg_rd_i,
  input  logic [1:0]  reg_be_i,
  input  logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // frame words from the queue manager
  input  logic        q_valid_i,
  input  logic [15:0] q_data_i,
  input  logic        q_last_i,
  input  logic [11:0] q_bytes_i,
  output logic        q_ready_o,
  // byte stream toward the line
  output logic        tx_valid_o,
  output logic [7:0]  tx_data_o,
  output logic        tx_last_o,
  input  logic        tx_ready_i,
  // flow control context
  input  logic        full_duplex_i,
  input  logic [LW-1:0] rx_level_i,
  input  logic [47:0] station_mac_i,
  output logic        backpressure_o,
  output logic        tx_running_o
);

  localparam logic [AW:0] P1       = (AW+1)'(1);
  localparam logic [AW:0] USED_MAX = (AW+1)'((1 << AW) - 2);

  typedef struct packed {
    logic [15:0]   ctrl;
    logic [15:0]   rdata;
    logic [AW:0]   wp;
    logic [AW:0]   rp;
    logic [AW:0]   commit;
    logic [AW-1:0] base;
    logic [AW-1:0] clr;
    logic [10:0]   wcnt;
    wr_e           wstate;
    logic          ip_ok;
    logic          frag;
    logic [7:0]    proto;
    logic [15:0]   totlen;
    logic [11:0]   flen;
    logic [31:0]   ipsum;
    logic [31:0]   psum;
    logic [31:0]   l4sum;
    logic          qrdy;
    tx_e           tstate;
    logic [11:0]   cnt;
    logic [11:0]   len;
    logic [31:0]   crc;
    logic          use_fcs;
    logic          use_pad;
    logic          pause_sent;
    logic          ov;
    logic [7:0]    od;
    logic          ol;
    logic [11:0]   ocnt;
    logic          bp;
    logic          run;
  } state_s;

  state_s       st;
  state_s       next_st;
  logic [15:0]  mem [0:(1 << AW) - 1];
  logic         mem_we;
  logic [AW-1:0] mem_wa;
  logic [15:0]  mem_wd;
  logic [15:0]  rword;
  logic         ld;
  logic         pc;
  logic         acc;
  logic         emit;
  logic         elast;
  logic [7:0]   eb;
  logic         reg_hit;

  // one's complement fold of a wide sum
  function automatic logic [15:0] fold(input logic [31:0] a);
    logic [16:0] s;
    s = {1'b0, a[15:0]} + {1'b0, a[31:16]};
    fold = s[15:0] + {15'h0000, s[16]};
  endfunction

  // word holding the layer-4 checksum, zero for protocols other than udp, tcp and icmp
  function automatic logic [10:0] csum_word(input logic [7:0] p);
    if (p == PROTO_UDP) csum_word = W_UDPCS;
    else if (p == PROTO_TCP) csum_word = W_TCPCS;
    else if (p == PROTO_ICMP) csum_word = W_ICMPCS;
    else csum_word = 11'h000;
  endfunction

  // reflected crc-32 over one byte, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  // pause frame header byte, zero beyond the 18-byte header
  function automatic logic [7:0] pbyte(input logic [143:0] v,
                                       input logic [11:0] i);
    logic [143:0] t;
    t = v << {i[4:0], 3'h0};
    pbyte = (i < PAUSE_HDR) ? t[143:136] : 8'h00;
  endfunction

  assign rword   = mem[st.rp[AW-1:0]];
  assign reg_hit = reg_addr_i[11:1] == TX_CTRL_ADDR[11:1];
  assign ld      = !st.ov || tx_ready_i;
  assign acc     = q_valid_i && st.qrdy;
  assign pc      = st.ctrl[FC_BIT] && full_duplex_i && !st.pause_sent &&
                   rx_level_i >= PAUSE_THRESH;

  // next state of the whole block
  always_comb begin
    next_st = st;
    mem_we  = 1'b0;
    mem_wa  = '0;
    mem_wd  = 16'h0000;
    emit    = 1'b0;
    elast   = 1'b0;
    eb      = 8'h00;
    // control register; reserved bits never stored
    if (reg_wr_i && reg_hit) begin
      if (reg_be_i[0]) next_st.ctrl[7:0] = reg_wdata_i[7:0];
      if (reg_be_i[1]) next_st.ctrl[15:8] = reg_wdata_i[15:8];
      next_st.ctrl = next_st.ctrl & TX_CTRL_WMASK;
    end
    if (reg_rd_i) next_st.rdata = reg_hit ? st.ctrl : 16'h0000;
    // queue writer: words in, header and checksums patched at the end
    case (st.wstate)
      Q_FILL: if (acc) begin
        mem_we = 1'b1;
        mem_wd = q_data_i;
        if (st.wcnt == 11'h000) begin
          next_st.base = st.wp[AW-1:0];
          mem_wa = st.wp[AW-1:0] + AW'(1);
          next_st.wp = st.wp + P1 + P1;
        end else begin
          mem_wa = st.wp[AW-1:0];
          next_st.wp = st.wp + P1;
        end
        next_st.wcnt = st.wcnt + 11'h001;
        if (st.wcnt == W_ETYPE) next_st.ip_ok = q_data_i == ETYPE_IPV4;
        if (st.wcnt == W_VER)
          next_st.ip_ok = st.ip_ok && q_data_i[15:8] == VER_IHL;
        if (st.wcnt == W_TOTLEN) next_st.totlen = q_data_i;
        if (st.wcnt == W_FRAG) next_st.frag = |(q_data_i & FRAG_MASK);
        if (st.wcnt == W_PROTO) next_st.proto = q_data_i[7:0];
        if (st.wcnt >= W_VER && st.wcnt <= W_IPEND && st.wcnt != W_IPCS)
          next_st.ipsum = st.ipsum + {16'h0000, q_data_i};
        if (st.wcnt >= W_SRC && st.wcnt <= W_IPEND)
          next_st.psum = st.psum + {16'h0000, q_data_i};
        if (st.wcnt >= W_L4 && st.wcnt != csum_word(st.proto))
          next_st.l4sum = st.l4sum + {16'h0000, q_data_i};
        if (q_last_i) begin
          next_st.flen = q_bytes_i;
          next_st.wstate = Q_LEN;
        end
      end
      Q_LEN: begin
        mem_we = 1'b1;
        mem_wa = st.base;
        mem_wd = {4'h0, st.flen};
        next_st.wstate = Q_IP;
      end
      Q_IP: begin
        if (st.ctrl[IPCS_BIT] && st.ip_ok && !st.frag) begin
          mem_we = 1'b1;
          mem_wa = st.base + AW'(W_IPCS + 11'h001);
          mem_wd = ~fold(st.ipsum);
        end
        next_st.wstate = Q_L4;
      end
      default: begin
        mem_wa = st.base + AW'(csum_word(st.proto) + 11'h001);
        if (st.ip_ok && !st.frag) begin
          if (st.proto == PROTO_ICMP && st.ctrl[ICMPCS_BIT]) begin
            mem_we = 1'b1;
            mem_wd = ~fold(st.l4sum);
          end else if ((st.proto == PROTO_UDP && st.ctrl[UDPCS_BIT]) ||
                       (st.proto == PROTO_TCP && st.ctrl[TCPCS_BIT])) begin
            mem_we = 1'b1;
            mem_wd = ~fold(st.l4sum + st.psum + {24'h000000, st.proto} +
                           {16'h0000, st.totlen - IP_HDR_LEN});
            // udp reserves zero for no checksum
            if (st.proto == PROTO_UDP && mem_wd == 16'h0000)
              mem_wd = 16'hFFFF;
          end
        end
        next_st.commit = st.wp;
        next_st.wcnt = 11'h000;
        next_st.ipsum = 32'h00000000;
        next_st.psum = 32'h00000000;
        next_st.l4sum = 32'h00000000;
        next_st.ip_ok = 1'b0;
        next_st.frag = 1'b0;
        next_st.proto = 8'h00;
        next_st.wstate = Q_FILL;
      end
    endcase
    // line side: one byte per free output slot
    if (ld) begin
      case (st.tstate)
        T_IDLE: begin
          next_st.cnt = 12'h000;
          next_st.crc = CRC_INIT;
          if (pc) begin
            next_st.tstate = T_PAUSE;
            next_st.pause_sent = 1'b1;
            next_st.use_fcs = 1'b1;
            next_st.use_pad = 1'b1;
          end else if (st.ctrl[RUN_BIT] && st.commit != st.rp) begin
            next_st.tstate = T_LEN;
          end
        end
        T_LEN: begin
          next_st.len = rword[11:0];
          next_st.rp = st.rp + P1;
          next_st.use_fcs = st.ctrl[FCS_BIT];
          next_st.use_pad = st.ctrl[PAD_BIT];
          next_st.tstate = T_DATA;
        end
        T_DATA: begin
          emit = 1'b1;
          eb = st.cnt[0] ? rword[7:0] : rword[15:8];
          if (st.cnt[0] || st.cnt + 12'h001 == st.len)
            next_st.rp = st.rp + P1;
        end
        T_PAD: emit = 1'b1;
        T_PAUSE: begin
          emit = 1'b1;
          eb = pbyte({PAUSE_DA, station_mac_i, PAUSE_TYPE, PAUSE_OP,
                      PAUSE_QUANTA}, st.cnt);
        end
        default: begin
          emit = 1'b1;
          eb = 8'(~st.crc >> {st.cnt[1:0], 3'h0});
          next_st.cnt = st.cnt + 12'h001;
          if (st.cnt[1:0] == FCS_LAST) begin
            elast = 1'b1;
            next_st.tstate = T_IDLE;
          end
        end
      endcase
      // data, pad and pause bytes all feed the crc
      if (emit && st.tstate != T_FCS) begin
        next_st.crc = crc_byte(st.crc, eb);
        next_st.cnt = st.cnt + 12'h001;
        if ((st.tstate == T_DATA && st.cnt + 12'h001 == st.len) ||
            (st.tstate != T_DATA && st.cnt + 12'h001 == MIN_DATA)) begin
          if (st.tstate == T_DATA && st.use_pad &&
              st.len < MIN_DATA) begin
            next_st.tstate = T_PAD;
          end else if (st.use_fcs) begin
            next_st.tstate = T_FCS;
            next_st.cnt = 12'h000;
          end else begin
            elast = 1'b1;
            next_st.tstate = T_IDLE;
          end
        end
      end
      next_st.ov = emit;
      next_st.od = eb;
      next_st.ol = elast;
    end
    if (tx_valid_o && tx_ready_i)
      next_st.ocnt = tx_last_o ? 12'h000 : st.ocnt + 12'h001;
    // flush: pointers home and memory wiped one word per cycle
    if (st.ctrl[FLUSH_BIT]) begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.commit = '0;
      next_st.wcnt = 11'h000;
      next_st.wstate = Q_FILL;
      next_st.ipsum = 32'h00000000;
      next_st.psum = 32'h00000000;
      next_st.l4sum = 32'h00000000;
      next_st.tstate = T_IDLE; // host stops transmit first
      next_st.ov = 1'b0;
      next_st.ocnt = 12'h000; // an aborted frame must not skew the next
      mem_we = 1'b1;
      mem_wa = st.clr;
      mem_wd = 16'h0000;
      next_st.clr = st.clr + AW'(1);
    end else begin
      next_st.clr = '0;
    end
    // rearm the pause once the receive level drops
    if (rx_level_i < PAUSE_THRESH) next_st.pause_sent = 1'b0;
    next_st.bp = st.ctrl[FC_BIT] && !full_duplex_i &&
                 rx_level_i >= PAUSE_THRESH;
    next_st.qrdy = next_st.wstate == Q_FILL &&
                   !next_st.ctrl[FLUSH_BIT] &&
                   (next_st.wp - next_st.rp) <= USED_MAX;
    next_st.run = next_st.ctrl[RUN_BIT] || next_st.tstate != T_IDLE;
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctrl <= TX_CTRL_RESET;
      st.wstate <= Q_FILL;
      st.tstate <= T_IDLE;
      st.crc <= CRC_INIT;
    end else begin
      st <= next_st;
    end
  end

  // queue memory, no reset: flush wipes it one word per cycle while held
  always_ff @(posedge clk_i) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  assign reg_rdata_o    = st.rdata;
  assign q_ready_o      = st.qrdy;
  assign tx_valid_o     = st.ov;
  assign tx_data_o      = st.od;
  assign tx_last_o      = st.ol;
  assign backpressure_o = st.bp;
  assign tx_running_o   = st.run;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fcs_go;
    ld && st.tstate == T_FCS && st.cnt == 12'h000;
  endsequence
  sequence s_first_fcs;
    tx_valid_o && tx_data_o == ~st.crc[7:0];
  endsequence

  property p_start;
    st.tstate == T_IDLE && ld && !pc && st.ctrl[RUN_BIT] &&
      st.commit != st.rp |=> st.tstate == T_LEN ##1 st.tstate == T_DATA;
  endproperty
  a_start: assert property (p_start) else $error("no frame start");
  property p_stopped;
    st.tstate == T_IDLE && !st.ctrl[RUN_BIT] |=> st.tstate != T_LEN;
  endproperty
  a_stopped: assert property (p_stopped) else $error("start while off");
  property p_flush;
    st.ctrl[FLUSH_BIT] |=> st.wp == '0 && st.rp == '0 && !tx_valid_o;
  endproperty
  a_flush: assert property (p_flush) else $error("flush kept queue");
  property p_pause;
    st.tstate == T_IDLE && ld && pc |=> st.tstate == T_PAUSE ##1 tx_valid_o;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not sent");
  property p_bp;
    st.ctrl[FC_BIT] && !full_duplex_i && rx_level_i >= PAUSE_THRESH
      |=> backpressure_o;
  endproperty
  a_bp: assert property (p_bp) else $error("no back-pressure");
  property p_nofc;
    !st.ctrl[FC_BIT] && st.tstate == T_IDLE
      |=> !backpressure_o && st.tstate != T_PAUSE;
  endproperty
  a_nofc: assert property (p_nofc) else $error("flow control off");
  property p_pad;
    tx_valid_o && tx_ready_i && tx_last_o && st.use_pad && st.use_fcs
      |-> st.ocnt >= 12'h03F;
  endproperty
  a_pad: assert property (p_pad) else $error("short padded frame");
  property p_fcs;
    s_fcs_go |=> s_first_fcs;
  endproperty
  a_fcs: assert property (p_fcs) else $error("bad first fcs byte");
  property p_ipcs;
    st.wstate == Q_IP && st.ctrl[IPCS_BIT] && st.ip_ok && !st.frag
      |-> mem_we && mem_wa == st.base + AW'(W_IPCS + 11'h001) &&
          fold(st.ipsum + {16'h0000, mem_wd}) == 16'hFFFF;
  endproperty
  a_ipcs: assert property (p_ipcs) else $error("ip checksum skipped");
  property p_rsv;
    reg_rd_i |=> reg_rdata_o[15:9] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule

// ===== src/mac_tx_pkg.sv
// constants for the transmit control block of the host queue manager
// assumes one 40 MHz clock shared by host port, queue writer and line side
package mac_tx_pkg;
  // register map and layout
  localparam logic [11:0] TX_CTRL_ADDR  = 12'h170;
  localparam logic [15:0] TX_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TX_CTRL_WMASK = 16'h01FF;
  localparam int RUN_BIT   = 0;
  localparam int FCS_BIT   = 1;
  localparam int PAD_BIT   = 2;
  localparam int FC_BIT    = 3;
  localparam int FLUSH_BIT = 4;
  localparam int IPCS_BIT  = 5;
  localparam int TCPCS_BIT = 6;
  localparam int UDPCS_BIT = 7;
  localparam int ICMPCS_BIT = 8;
  // frame sizes in bytes; the fcs brings a padded frame to 64
  localparam logic [11:0] MIN_DATA   = 12'h03C;
  localparam logic [1:0]  FCS_LAST   = 2'h3;
  localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
  // 16-bit word positions inside a frame, first byte in bits 15:8
  localparam logic [10:0] W_ETYPE  = 11'h006;
  localparam logic [10:0] W_VER    = 11'h007;
  localparam logic [10:0] W_TOTLEN = 11'h008;
  localparam logic [10:0] W_FRAG   = 11'h00A;
  localparam logic [10:0] W_PROTO  = 11'h00B;
  localparam logic [10:0] W_IPCS   = 11'h00C;
  localparam logic [10:0] W_SRC    = 11'h00D;
  localparam logic [10:0] W_IPEND  = 11'h010;
  localparam logic [10:0] W_L4     = 11'h011;
  localparam logic [10:0] W_ICMPCS = 11'h012;
  localparam logic [10:0] W_UDPCS  = 11'h014;
  localparam logic [10:0] W_TCPCS  = 11'h019;
  localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
  localparam logic [7:0]  VER_IHL    = 8'h45;
  localparam logic [15:0] FRAG_MASK  = 16'h3FFF;
  localparam logic [15:0] IP_HDR_LEN = 16'h0014;
  localparam logic [7:0]  PROTO_ICMP = 8'h01;
  localparam logic [7:0]  PROTO_TCP  = 8'h06;
  localparam logic [7:0]  PROTO_UDP  = 8'h11;
  // pause frame header fields
  localparam logic [47:0] PAUSE_DA   = 48'h0180C2000001;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OP   = 16'h0001;
  localparam logic [11:0] PAUSE_HDR  = 12'h012;
  // queue writer and line side states
  typedef enum logic [3:0] {
    Q_FILL = 4'h1, Q_LEN = 4'h2, Q_IP = 4'h4, Q_L4 = 4'h8
  } wr_e;
  typedef enum logic [5:0] {
    T_IDLE = 6'h01, T_LEN = 6'h02, T_DATA = 6'h04,
    T_PAD = 6'h08, T_FCS = 6'h10, T_PAUSE = 6'h20
  } tx_e;
endpackage

// ===== verification/line_sink.sv
// line-side partner: takes transmit bytes and keeps them in order
// assumes the byte stream runs on clk_i; stall_i halves the accept rate
`timescale 1ns/10ps
module line_sink (
  // clock and reset
  input  logic       clk_i,
  input  logic       rst_i,
  // byte stream from the block
  input  logic       tx_valid_i,
  input  logic [7:0] tx_data_i,
  input  logic       tx_last_i,
  input  logic       stall_i,
  output logic       tx_ready_o
);
  logic [7:0] got[$];
  int         frames;

  // ready toggles while stalling so the block must hold each byte
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      frames     <= 0;
    end else begin
      tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        got.push_back(tx_data_i);
        if (tx_last_i) begin
          frames <= frames + 1;
        end
      end
    end
  end
endmodule

// ===== verification/tb_mac_transmit_control.sv
// testbench for the transmit control block with a line-side sink
// assumes one 40 MHz clock; bench drives inputs on the falling edge
`timescale 1ns/10ps
module tb_mac_transmit_control;
  import mac_tx_pkg::*;
  localparam logic [10:0] THRESH = 11'h064;
  localparam logic [15:0] QUANTA = 16'h0040;
  localparam logic [47:0] MAC    = 48'h020000000001;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] reg_addr_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [1:0]  reg_be_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic        q_valid_i;
  logic [15:0] q_data_i;
  logic        q_last_i;
  logic [11:0] q_bytes_i;
  logic        q_ready_o;
  logic        tx_valid_o;
  logic [7:0]  tx_data_o;
  logic        tx_last_o;
  logic        tx_ready_i;
  logic        full_duplex_i;
  logic [10:0] rx_level_i;
  logic        backpressure_o;
  logic        tx_running_o;
  logic        stall;
  int          error_cnt;
  int          tests_run;
  int          base;

  always #12.5 clk_i = ~clk_i;

  mac_transmit_control #(.PAUSE_THRESH(THRESH), .PAUSE_QUANTA(QUANTA)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .q_valid_i(q_valid_i), .q_data_i(q_data_i), .q_last_i(q_last_i),
    .q_bytes_i(q_bytes_i), .q_ready_o(q_ready_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
    .full_duplex_i(full_duplex_i), .rx_level_i(rx_level_i),
    .station_mac_i(MAC), .backpressure_o(backpressure_o),
    .tx_running_o(tx_running_o));

  line_sink S (
    .clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .stall_i(stall),
    .tx_ready_o(tx_ready_i));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_i  = TX_CTRL_ADDR;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask

  // one word a cycle; an odd last byte rides in the high lane
  task automatic send(input logic [7:0] b[$]);
    int n;
    n = (b.size() + 1) / 2;
    for (int k = 0; k < n; k++) begin
      @(negedge clk_i);
      q_valid_i = 1'b1;
      q_data_i  = {b[2*k], (2*k+1 < b.size()) ? b[2*k+1] : 8'h00};
      q_last_i  = (k == n - 1);
      q_bytes_i = 12'(b.size());
      while (!q_ready_o) @(negedge clk_i);
      @(posedge clk_i);
    end
    @(negedge clk_i);
    q_valid_i = 1'b0;
    q_last_i  = 1'b0;
  endtask

  task automatic expect_out(input logic [7:0] e[$]);
    repeat (3000) if (S.frames == base) @(negedge clk_i);
    chk("frames", S.frames, base + 1);
    chk("length", S.got.size(), e.size());
    foreach (e[i]) chk("byte", S.got[i], e[i]);
    S.got.delete();
    base = S.frames;
  endtask

  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ 32'(b[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  // pads to 60 and appends the fcs low byte first
  function automatic void pad_fcs(ref logic [7:0] e[$]);
    logic [31:0] c;
    while (e.size() < 60) e.push_back(8'h00);
    c = crc(e);
    for (int i = 0; i < 4; i++) e.push_back(c[8*i +: 8]);
  endfunction

  task automatic s_regs();
    logic [15:0] d;
    reg_rd(TX_CTRL_ADDR, d);
    chk("ctrl reset", d, TX_CTRL_RESET);
    reg_wr(16'hFFEF);
    reg_rd(TX_CTRL_ADDR, d);
    chk("ctrl mask", d, 16'h01EF);
    reg_rd(12'h172, d);
    chk("unmapped", d, 16'h0000);
    reg_be_i = 2'h2;
    reg_wr(16'h0000);
    reg_be_i = 2'h3;
    reg_rd(TX_CTRL_ADDR, d);
    chk("low lane kept", d, 16'h00EF);
    reg_wr(16'h0000);
  endtask

  task automatic s_plain();
    logic [7:0] f[$];
    for (int i = 0; i < 15; i++) f.push_back(8'(i + 1));
    reg_wr(16'h0001);
    repeat (2) @(negedge clk_i);
    chk("running", tx_running_o, 1'b1);
    send(f);
    expect_out(f);
  endtask

  task automatic s_pad();
    logic [7:0] f[$];
    logic [7:0] e[$];
    for (int i = 0; i < 15; i++) f.push_back(8'(8'hA0 + i));
    e = f;
    pad_fcs(e);
    stall = 1'b1;
    reg_wr(16'h0007);
    send(f);
    expect_out(e);
    stall = 1'b0;
  endtask

  task automatic s_csum();
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [15:0] w[31];
    logic [7:0]  pr[4] = '{PROTO_ICMP, PROTO_UDP, PROTO_TCP, PROTO_TCP};
    logic [31:0] s;
    logic [31:0] t;
    int          ci;
    reg_wr(16'h01E1);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 31; k++) w[k] = 16'(k) * 16'h0113;
      ci = (c == 0) ? W_ICMPCS : (c == 1) ? W_UDPCS : W_TCPCS;
      w[W_ETYPE]  = ETYPE_IPV4;
      w[W_VER]    = {VER_IHL, 8'h00};
      w[W_TOTLEN] = 16'h0030;
      w[W_FRAG]   = (c == 3) ? 16'h2000 : 16'h0000;
      w[W_PROTO]  = {8'h40, pr[c]};
      w[W_IPCS]   = 16'h0000;
      w[ci]       = 16'h0000;
      if (c == 1) w[19] = 16'h001C;
      f = {};
      foreach (w[k]) f.push_back(w[k][15:8]);
      foreach (w[k]) f.insert(2 * k + 1, w[k][7:0]);
      s = 0;
      t = 0;
      for (int k = 7; k < 17; k++) if (k != W_IPCS) s += w[k];
      for (int k = 17; k < 31; k++) if (k != ci) t += w[k];
      if (c > 0) t += w[13] + w[14] + w[15] + w[16] + pr[c] + 16'h001C;
      repeat (2) s = s[15:0] + s[31:16];
      repeat (2) t = t[15:0] + t[31:16];
      e = f;
      if (c < 3) begin
        e[2*W_IPCS]   = ~s[15:8];
        e[2*W_IPCS+1] = ~s[7:0];
        e[2*ci]       = ~t[15:8];
        e[2*ci+1]     = ~t[7:0];
      end
      send(f);
      expect_out(e);
    end
  endtask

  task automatic s_stop();
    logic [7:0] f[$];
    for (int i = 0; i < 40; i++) f.push_back(8'(i * 3));
    stall = 1'b1;
    reg_wr(16'h0001);
    send(f);
    repeat (100) if (!tx_valid_o) @(negedge clk_i);
    reg_wr(16'h0000);
    expect_out(f);
    send(f);
    repeat (80) @(negedge clk_i);
    chk("held frames", S.frames, base);
    chk("stopped", tx_running_o, 1'b0);
    reg_wr(16'h0010);
    reg_wr(16'h0000);
    reg_wr(16'h0001);
    repeat (80) @(negedge clk_i);
    chk("flushed", S.got.size(), 0);
    stall = 1'b0;
  endtask

  task automatic s_flow();
    logic [7:0] e[$];
    for (int i = 5; i >= 0; i--) e.push_back(PAUSE_DA[8*i +: 8]);
    for (int i = 5; i >= 0; i--) e.push_back(MAC[8*i +: 8]);
    e.push_back(PAUSE_TYPE[15:8]);
    e.push_back(PAUSE_TYPE[7:0]);
    e.push_back(PAUSE_OP[15:8]);
    e.push_back(PAUSE_OP[7:0]);
    e.push_back(QUANTA[15:8]);
    e.push_back(QUANTA[7:0]);
    pad_fcs(e);
    full_duplex_i = 1'b1;
    rx_level_i    = THRESH;
    reg_wr(16'h0009);
    expect_out(e);
    full_duplex_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("backpressure", backpressure_o, 1'b1);
    reg_wr(16'h0001);
    repeat (4) @(negedge clk_i);
    chk("no backpressure", backpressure_o, 1'b0);
  endtask

  initial begin
    reg_addr_i    = 12'h000;
    reg_wr_i      = 1'b0;
    reg_rd_i      = 1'b0;
    reg_be_i      = 2'h3;
    reg_wdata_i   = 16'h0000;
    q_valid_i     = 1'b0;
    q_data_i      = 16'h0000;
    q_last_i      = 1'b0;
    q_bytes_i     = 12'h000;
    full_duplex_i = 1'b1;
    rx_level_i    = 11'h000;
    stall         = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    s_regs();
    s_plain();
    s_pad();
    s_csum();
    s_stop();
    s_flow();
    report_and_stop();
  end

  // the whole run needs about a thousand cycles; this cuts a hang short
  initial begin
    #(40000 * 25);
    error_cnt++;
    report_and_stop();
  end
endmodule
